// file: logic/etdm_defines.svh
`ifndef ETDM_DEFINES_SVH
`define ETDM_DEFINES_SVH
// descriptor layout and addressing
`define ETDM_W1_OFS      32'h0000_0004
`define ETDM_DESC_STRIDE 32'h0000_0008
`define ETDM_WORD_MASK   32'hffff_fffc
`define ETDM_BIT_USED    31
`define ETDM_BIT_WRAP    30
`define ETDM_BIT_RETRY   29
`define ETDM_BIT_UNDR    28
`define ETDM_BIT_EXH     27
`define ETDM_RSV_MSB     26
`define ETDM_BIT_NOCRC   16
`define ETDM_BIT_LAST    15
`define ETDM_LEN_MSB     10
// frame padding: pad to this count, the mac then appends four crc bytes
`define ETDM_PAD_MIN     7'h3c
`define ETDM_CNT_SAT     7'h7f
`define ETDM_QDEPTH      1024
`define ETDM_QIDX_W      10
`endif

// file: logic/etdm_pkg.sv
`default_nettype none
package etdm_pkg;
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_RD_CTRL,
    ST_RD_ADDR,
    ST_RD_DATA,
    ST_OUT,
    ST_PAD,
    ST_END,
    ST_RESULT,
    ST_ERR,
    ST_WB
  } etdm_state_t;
endpackage
`default_nettype wire

// file: logic/etdm_qptr.sv
`include "etdm_defines.svh"
`default_nettype none
module etdm_qptr #(
  parameter int IDX_W = `ETDM_QIDX_W,
  parameter int DEPTH = `ETDM_QDEPTH
) (
  input  wire logic             clk_i,         // system clock
  input  wire logic             rst_i,         // sync reset, high
  input  wire logic             load_i,        // new list base written
  input  wire logic [31:0]      base_i,        // new list base
  input  wire logic             start_i,       // back to list start
  input  wire logic             adv_i,         // step to next descriptor
  input  wire logic             wrap_i,        // current descriptor is last in list
  input  wire logic             restore_i,     // back to saved index
  input  wire logic [IDX_W-1:0] restore_idx_i, // saved index
  output logic      [IDX_W-1:0] idx_o,         // current index
  output logic      [31:0]      addr_o         // current descriptor address
);
  logic [IDX_W-1:0] idx_r;
  logic [IDX_W-1:0] idx_nxt;
  logic [31:0]      base_r;
  logic [31:0]      base_nxt;
  logic [31:0]      addr_nxt;
  wire              at_top = (idx_r == IDX_W'(DEPTH - 1));

  assign base_nxt = load_i ? base_i : base_r;
  always_comb
  begin
    idx_nxt = idx_r;
    if (load_i || start_i)
      idx_nxt = '0;
    else if (restore_i)
      idx_nxt = restore_idx_i;
    else if (adv_i)
      idx_nxt = (wrap_i || at_top) ? '0 : idx_r + IDX_W'(1);
  end
  assign addr_nxt = base_nxt + 32'(idx_nxt) * `ETDM_DESC_STRIDE;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      idx_r  <= '0;
      base_r <= '0;
      addr_o <= '0;
    end
    else
    begin
      idx_r  <= idx_nxt;
      base_r <= base_nxt;
      addr_o <= addr_nxt;
    end
  end
  assign idx_o = idx_r;
endmodule
`default_nettype wire

// file: logic/etdm_top.sv
// Operation
// - buffer lengths 0 to 2047 bytes accepted, zero length included.
// - descriptor is two words: buffer byte address, then control and status.
// - with crc appended, frame is padded to reach 64 bytes total.
// - no-crc bit in last buffer suppresses crc and pad for frame.
// - last-buffer bit ends frame; low eleven bits give buffer length.
// - used bit must be clear to send; set in first buffer after send.
// - control word written back to first descriptor with used and status.
// - status bits flag retry limit, underrun and buffers exhausted mid-frame.
// - wrap bit returns fetch to list start; rollover after 1024 descriptors.
// - writing list pointer resets queue pointer to new list start.
// - transmit disable resets queue pointer to list start.
// - start command sets transmit-active; repeating it is harmless.
// - transmit-active clears on disable, used fetch, pointer write, halt, error.
// - halt waits until the frame in progress has finished.
// - collision restarts the frame from its first descriptor.
// - used bit mid-frame is an error: stop, phy error, bad fcs.
// - transmit error resets queue pointer to list start.
// - used bit at frame start stops but keeps the queue pointer.
// - pause enabled with pause active holds off new frames.
`include "etdm_defines.svh"
`default_nettype none
module etdm_top
  import etdm_pkg::*;
#(
  parameter int QDEPTH = `ETDM_QDEPTH
) (
  input  wire logic        REF_CLK_I,          // system clock
  input  wire logic        RST_I,              // sync reset, high
  input  wire logic        TX_ENABLE_I,        // transmit enable level
  input  wire logic        TX_START_I,         // start write pulse
  input  wire logic        TX_HALT_I,          // halt write pulse
  input  wire logic        TBQP_WR_I,          // list pointer write pulse
  input  wire logic [31:0] TBQP_DATA_I,        // list pointer value
  input  wire logic        PAUSE_EN_I,         // pause enable setting
  input  wire logic        PAUSE_ACTIVE_I,     // pause time non-zero
  input  wire logic        TX_DONE_I,          // mac: frame sent pulse
  input  wire logic        TX_COLLISION_I,     // mac: collision pulse
  input  wire logic        TX_RETRY_LIMIT_I,   // mac: retry limit pulse
  input  wire logic        TX_LATE_I,          // mac: data came too late
  input  wire logic        TX_BYTE_READY_I,    // mac takes byte
  output logic      [7:0]  TX_BYTE_O,          // frame byte
  output logic             TX_BYTE_VALID_O,    // frame byte valid
  output logic             TX_FRAME_END_O,     // frame end pulse
  output logic             TX_ADD_CRC_O,       // with end: append crc
  output logic             TX_BAD_FCS_O,       // with end: corrupt fcs
  output logic             PHY_TX_ERROR_O,     // phy_tx_error_signal pulse
  output logic             TX_GO_O,            // transmit-active flag
  output logic      [31:0] TX_QUEUE_PTR_O,     // current descriptor address
  output logic             MEM_REQ_O,          // memory request
  output logic             MEM_WE_O,           // memory write
  output logic      [31:0] MEM_ADDR_O,         // memory byte address
  output logic      [31:0] MEM_WDATA_O,        // memory write data
  input  wire logic        MEM_ACK_I,          // memory done
  input  wire logic        MEM_ERR_I,          // memory bus error, with ack
  input  wire logic [31:0] MEM_RDATA_I         // memory read data
);
  localparam int IW = `ETDM_QIDX_W;

  etdm_state_t st_r, st_nxt;
  logic [31:0] ctrl_r, ctrl_nxt, first_ctrl_r, first_ctrl_nxt;
  logic [31:0] first_addr_r, first_addr_nxt, baddr_r, baddr_nxt, data_r, data_nxt;
  logic [IW-1:0] first_idx_r, first_idx_nxt;
  logic [`ETDM_LEN_MSB:0] rem_r, rem_nxt;
  logic [6:0]  cnt_r, cnt_nxt;
  logic        first_buf_r, first_buf_nxt, word_ok_r, word_ok_nxt, err_r, err_nxt;
  logic [2:0]  stat_r, stat_nxt;
  logic        go_nxt, req_nxt, we_nxt, valid_nxt, end_nxt, crc_nxt, bad_nxt, perr_nxt;
  logic [31:0] addr_nxt, wdata_nxt;
  logic [7:0]  byte_nxt;
  logic        q_start, q_adv, q_restore, stop_used, tx_err;
  logic [IW-1:0] q_idx;
  logic [31:0] q_addr;

  wire ack      = MEM_REQ_O & MEM_ACK_I;
  wire rd_used  = MEM_RDATA_I[`ETDM_BIT_USED];
  wire paused   = PAUSE_EN_I & PAUSE_ACTIVE_I;
  wire active   = (st_r == ST_RD_CTRL) || (st_r == ST_RD_ADDR) || (st_r == ST_RD_DATA) ||
                  (st_r == ST_OUT) || (st_r == ST_PAD) || (st_r == ST_END) || (st_r == ST_RESULT);
  wire take     = ~TX_BYTE_VALID_O | TX_BYTE_READY_I;
  wire add_crc  = ~ctrl_r[`ETDM_BIT_NOCRC];
  wire [7:0] sel_byte = data_r[{baddr_r[1:0], 3'b000} +: 8];
  wire [6:0] cnt_inc  = (cnt_r == `ETDM_CNT_SAT) ? cnt_r : cnt_r + 7'h1;
  wire [31:0] wb_word = {1'b1, first_ctrl_r[`ETDM_BIT_WRAP], stat_r, first_ctrl_r[`ETDM_RSV_MSB:0]};

  etdm_qptr #(
    .IDX_W (IW),
    .DEPTH (QDEPTH)
  ) u_qptr (
    .clk_i         (REF_CLK_I),
    .rst_i         (RST_I),
    .load_i        (TBQP_WR_I),
    .base_i        (TBQP_DATA_I),
    .start_i       (q_start),
    .adv_i         (q_adv),
    .wrap_i        (ctrl_r[`ETDM_BIT_WRAP]),
    .restore_i     (q_restore),
    .restore_idx_i (first_idx_r),
    .idx_o         (q_idx),
    .addr_o        (q_addr)
  );

  // set wins over every clear except disable, which also stops the walker
  always_comb
  begin
    if (!TX_ENABLE_I)
      go_nxt = 1'b0;
    else if (TX_START_I)
      go_nxt = 1'b1;
    else if (TBQP_WR_I || TX_HALT_I || stop_used || tx_err)
      go_nxt = 1'b0;
    else
      go_nxt = TX_GO_O;
  end

  always_comb
  begin
    st_nxt = st_r;
    ctrl_nxt = ctrl_r;
    first_ctrl_nxt = first_ctrl_r;
    first_addr_nxt = first_addr_r;
    first_idx_nxt = first_idx_r;
    baddr_nxt = baddr_r;
    data_nxt = data_r;
    rem_nxt = rem_r;
    cnt_nxt = cnt_r;
    first_buf_nxt = first_buf_r;
    word_ok_nxt = word_ok_r;
    err_nxt = err_r;
    stat_nxt = stat_r;
    req_nxt = MEM_REQ_O & ~MEM_ACK_I;
    we_nxt = MEM_WE_O;
    addr_nxt = MEM_ADDR_O;
    wdata_nxt = MEM_WDATA_O;
    valid_nxt = TX_BYTE_VALID_O & ~TX_BYTE_READY_I;
    byte_nxt = TX_BYTE_O;
    end_nxt = 1'b0;
    crc_nxt = TX_ADD_CRC_O;
    bad_nxt = TX_BAD_FCS_O;
    perr_nxt = 1'b0;
    q_start = 1'b0;
    q_adv = 1'b0;
    q_restore = 1'b0;
    stop_used = 1'b0;
    tx_err = 1'b0;
    if (!TX_ENABLE_I || TBQP_WR_I)
    begin
      st_nxt = ST_IDLE;
      q_start = ~TX_ENABLE_I;
      req_nxt = 1'b0;
      valid_nxt = 1'b0;
    end
    else if (active && TX_COLLISION_I)
    begin
      st_nxt = ST_RD_CTRL;
      q_restore = 1'b1;
      req_nxt = 1'b0;
      valid_nxt = 1'b0;
      cnt_nxt = '0;
      first_buf_nxt = 1'b1;
    end
    else if (active && ack && MEM_ERR_I)
    begin
      st_nxt = ST_ERR;
      stat_nxt = 3'b010;
    end
    else
    begin
      case (st_r)
        ST_IDLE:
          // halt only lowers the flag, so a running frame always completes here first
          if (TX_GO_O && !paused)
          begin
            st_nxt = ST_RD_CTRL;
            first_idx_nxt = q_idx;
            first_addr_nxt = q_addr;
            first_buf_nxt = 1'b1;
            cnt_nxt = '0;
            stat_nxt = '0;
            err_nxt = 1'b0;
          end
        ST_RD_CTRL:
          if (!MEM_REQ_O)
          begin
            req_nxt = 1'b1;
            we_nxt = 1'b0;
            addr_nxt = q_addr + `ETDM_W1_OFS;
          end
          else if (ack && rd_used && first_buf_r)
          begin
            st_nxt = ST_IDLE;
            stop_used = 1'b1;
          end
          else if (ack && rd_used)
          begin
            st_nxt = ST_ERR;
            stat_nxt = 3'b011;
          end
          else if (ack)
          begin
            st_nxt = ST_RD_ADDR;
            ctrl_nxt = MEM_RDATA_I;
            if (first_buf_r)
              first_ctrl_nxt = MEM_RDATA_I;
          end
        ST_RD_ADDR:
          if (!MEM_REQ_O)
          begin
            req_nxt = 1'b1;
            addr_nxt = q_addr;
          end
          else if (ack)
          begin
            st_nxt = ST_OUT;
            baddr_nxt = MEM_RDATA_I;
            rem_nxt = ctrl_r[`ETDM_LEN_MSB:0];
            word_ok_nxt = 1'b0;
          end
        ST_RD_DATA:
          if (!MEM_REQ_O)
          begin
            req_nxt = 1'b1;
            addr_nxt = baddr_r & `ETDM_WORD_MASK;
          end
          else if (ack)
          begin
            st_nxt = ST_OUT;
            data_nxt = MEM_RDATA_I;
            word_ok_nxt = 1'b1;
          end
        ST_OUT:
          if (take)
          begin
            if (rem_r == '0)
            begin
              q_adv = 1'b1;
              first_buf_nxt = 1'b0;
              if (!ctrl_r[`ETDM_BIT_LAST])
                st_nxt = ST_RD_CTRL;
              else if (add_crc && cnt_r < `ETDM_PAD_MIN)
                st_nxt = ST_PAD;
              else
                st_nxt = ST_END;
            end
            else if (!word_ok_r)
              st_nxt = ST_RD_DATA;
            else
            begin
              valid_nxt = 1'b1;
              byte_nxt = sel_byte;
              rem_nxt = rem_r - 11'h1;
              baddr_nxt = baddr_r + 32'h0000_0001;
              cnt_nxt = cnt_inc;
              if (baddr_r[1:0] == 2'b11)
                word_ok_nxt = 1'b0;
            end
          end
        ST_PAD:
          if (take)
          begin
            if (cnt_r < `ETDM_PAD_MIN)
            begin
              valid_nxt = 1'b1;
              byte_nxt = 8'h00;
              cnt_nxt = cnt_inc;
            end
            else
              st_nxt = ST_END;
          end
        ST_END:
          if (take)
          begin
            st_nxt = ST_RESULT;
            end_nxt = 1'b1;
            crc_nxt = add_crc;
            bad_nxt = 1'b0;
          end
        ST_RESULT:
          if (TX_DONE_I)
            st_nxt = ST_WB;
          else if (TX_RETRY_LIMIT_I || TX_LATE_I)
          begin
            st_nxt = ST_WB;
            err_nxt = 1'b1;
            tx_err = 1'b1;
            stat_nxt = {TX_RETRY_LIMIT_I, TX_LATE_I, 1'b0};
          end
        ST_ERR:
          if (take)
          begin
            st_nxt = ST_WB;
            end_nxt = 1'b1;
            bad_nxt = 1'b1;
            crc_nxt = 1'b0;
            perr_nxt = 1'b1;
            err_nxt = 1'b1;
            tx_err = 1'b1;
            req_nxt = 1'b0;
          end
        ST_WB:
          if (!MEM_REQ_O)
          begin
            req_nxt = 1'b1;
            we_nxt = 1'b1;
            addr_nxt = first_addr_r + `ETDM_W1_OFS;
            wdata_nxt = wb_word;
          end
          else if (ack)
          begin
            st_nxt = ST_IDLE;
            we_nxt = 1'b0;
            q_start = err_r | MEM_ERR_I;
          end
        default:
          st_nxt = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      st_r <= ST_IDLE;
      {ctrl_r, first_ctrl_r, first_addr_r, baddr_r, data_r} <= '0;
      {first_idx_r, rem_r, cnt_r, stat_r} <= '0;
      {first_buf_r, word_ok_r, err_r} <= '0;
      {TX_GO_O, MEM_REQ_O, MEM_WE_O, MEM_ADDR_O, MEM_WDATA_O} <= '0;
      {TX_BYTE_O, TX_BYTE_VALID_O, TX_FRAME_END_O, TX_ADD_CRC_O, TX_BAD_FCS_O, PHY_TX_ERROR_O} <= '0;
    end
    else
    begin
      st_r <= st_nxt;
      {ctrl_r, first_ctrl_r, first_addr_r, baddr_r, data_r} <=
        {ctrl_nxt, first_ctrl_nxt, first_addr_nxt, baddr_nxt, data_nxt};
      {first_idx_r, rem_r, cnt_r, stat_r} <= {first_idx_nxt, rem_nxt, cnt_nxt, stat_nxt};
      {first_buf_r, word_ok_r, err_r} <= {first_buf_nxt, word_ok_nxt, err_nxt};
      {TX_GO_O, MEM_REQ_O, MEM_WE_O, MEM_ADDR_O, MEM_WDATA_O} <= {go_nxt, req_nxt, we_nxt, addr_nxt, wdata_nxt};
      {TX_BYTE_O, TX_BYTE_VALID_O, TX_FRAME_END_O, TX_ADD_CRC_O, TX_BAD_FCS_O, PHY_TX_ERROR_O} <=
        {byte_nxt, valid_nxt, end_nxt, crc_nxt, bad_nxt, perr_nxt};
    end
  end
  assign TX_QUEUE_PTR_O = q_addr;

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);

  wire ctrl_ack = (st_r == ST_RD_CTRL) && ack && !MEM_ERR_I && TX_ENABLE_I && !TBQP_WR_I && !TX_COLLISION_I;

  a_start_sets_go: assert property (TX_ENABLE_I && TX_START_I |=> TX_GO_O)
    else $error("start did not set transmit-active");
  a_disable_clears: assert property (!TX_ENABLE_I |=> !TX_GO_O && st_r == ST_IDLE && q_idx == '0)
    else $error("disable did not stop and rewind");
  a_ptrwr_clears: assert property (TBQP_WR_I && !TX_START_I |=> !TX_GO_O && q_idx == '0)
    else $error("pointer write did not clear and rewind");
  a_used_first_stop: assert property (ctrl_ack && rd_used && first_buf_r && !TX_START_I
    |=> st_r == ST_IDLE && !TX_GO_O && q_idx == $past(q_idx))
    else $error("used at frame start mishandled");
  a_used_mid_error: assert property (ctrl_ack && rd_used && !first_buf_r
    |=> st_r == ST_ERR ##[1:9] (PHY_TX_ERROR_O && TX_BAD_FCS_O && TX_FRAME_END_O))
    else $error("mid-frame used not flagged as error");
  a_pause_holds: assert property (st_r == ST_IDLE && paused && TX_ENABLE_I |=> st_r == ST_IDLE)
    else $error("frame started while paused");
  a_pad_minimum: assert property (TX_FRAME_END_O && TX_ADD_CRC_O |-> cnt_r >= `ETDM_PAD_MIN)
    else $error("crc frame shorter than pad minimum");
  a_wb_target: assert property (MEM_REQ_O && MEM_WE_O
    |-> MEM_WDATA_O[`ETDM_BIT_USED] && MEM_ADDR_O == first_addr_r + `ETDM_W1_OFS)
    else $error("write-back word or address wrong");
  a_coll_restart: assert property (active && TX_COLLISION_I && TX_ENABLE_I && !TBQP_WR_I
    |=> st_r == ST_RD_CTRL && q_idx == first_idx_r && cnt_r == '0)
    else $error("collision did not restart frame");
  a_halt_waits: assert property (st_r == ST_OUT && TX_HALT_I && TX_ENABLE_I && !TBQP_WR_I
    && !TX_COLLISION_I |=> st_r != ST_IDLE)
    else $error("halt cut a frame short");

  c_frame_done: cover property (st_r == ST_WB && ack && !err_r);
  c_collision: cover property (active && TX_COLLISION_I);
  c_padded: cover property (st_r == ST_PAD && TX_BYTE_VALID_O);
  c_mid_used: cover property (ctrl_ack && rd_used && !first_buf_r);
endmodule
`default_nettype wire

// file: tb/etdm_mem_model.sv
`default_nettype none
module etdm_mem_model (
  input  wire logic        clk_i,      // system clock
  input  wire logic        rst_i,      // sync reset, high
  input  wire logic        req_i,      // request
  input  wire logic        we_i,       // write
  input  wire logic [31:0] addr_i,     // byte address
  input  wire logic [31:0] wdata_i,    // write data
  input  wire logic [31:0] err_addr_i, // address answered with bus error
  output logic             ack_o,      // done pulse
  output logic             err_o,      // bus error, with ack
  output logic      [31:0] rdata_o     // read data, with ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [0:255];
  logic [31:0] wb_a;
  logic [31:0] wb_d;
  int          n_wr = 0;
  int          n_rd = 0;
  logic [1:0]  wait_r;
  logic        slow_r;
  // answers alternate prompt and slow; data is inverted every cycle outside ack, so a stale value holds for one cycle only
  always @(posedge clk_i)
  begin
    ack_o <= 1'b0;
    err_o <= 1'b0;
    rdata_o <= ~rdata_o;
    if (rst_i)
    begin
      wait_r <= 2'h0;
      slow_r <= 1'b0;
      rdata_o <= 32'h5a5a_0f0f;
    end
    else if (req_i && !ack_o)
    begin
      wait_r <= wait_r + 2'h1;
      if (wait_r == {slow_r, slow_r})
      begin
        ack_o <= 1'b1;
        wait_r <= 2'h0;
        slow_r <= ~slow_r;
        err_o <= (addr_i == err_addr_i);
        if (we_i)
        begin
          mem[addr_i[9:2]] <= wdata_i;
          wb_a <= addr_i;
          wb_d <= wdata_i;
          n_wr <= n_wr + 1;
        end
        else
        begin
          rdata_o <= mem[addr_i[9:2]];
          n_rd <= n_rd + 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/etdm_top_bench.sv
`default_nettype none
module etdm_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int P_GO = 0, P_HALT = 1, P_QWR = 2, P_DONE = 3, P_COLL = 4, P_RETRY = 5, P_LATE = 6;
  logic        clk = 1'b0, rst = 1'b1, en = 1'b1, pen = 1'b0, pact = 1'b0, rdy = 1'b0;
  logic        start = 1'b0, halt = 1'b0, qwr = 1'b0, done = 1'b0, coll = 1'b0, retry = 1'b0, late = 1'b0;
  logic [31:0] err_addr = 32'hffff_ffff;
  logic [7:0]  byte_w, b0;
  logic        bval, fend, crc, bad, phy, go, req, we, ack, merr, crc_r, bad_r, phy_r;
  logic [31:0] qptr, maddr, mwdata, mrdata;
  logic [31:0] exp_st [3] = '{32'ha000_8001, 32'h9000_8001, 32'h9000_8001};
  int          nb = 0, fb = 0, nf = 0, n_fail = 0, n_compared = 0;

  etdm_top #(.QDEPTH(4)) dut (
    .REF_CLK_I(clk), .RST_I(rst), .TX_ENABLE_I(en), .TX_START_I(start), .TX_HALT_I(halt),
    .TBQP_WR_I(qwr), .TBQP_DATA_I(32'h0000_0100), .PAUSE_EN_I(pen), .PAUSE_ACTIVE_I(pact),
    .TX_DONE_I(done), .TX_COLLISION_I(coll), .TX_RETRY_LIMIT_I(retry), .TX_LATE_I(late),
    .TX_BYTE_READY_I(rdy), .TX_BYTE_O(byte_w), .TX_BYTE_VALID_O(bval), .TX_FRAME_END_O(fend),
    .TX_ADD_CRC_O(crc), .TX_BAD_FCS_O(bad), .PHY_TX_ERROR_O(phy), .TX_GO_O(go), .TX_QUEUE_PTR_O(qptr),
    .MEM_REQ_O(req), .MEM_WE_O(we), .MEM_ADDR_O(maddr), .MEM_WDATA_O(mwdata), .MEM_ACK_I(ack),
    .MEM_ERR_I(merr), .MEM_RDATA_I(mrdata));
  etdm_mem_model far (
    .clk_i(clk), .rst_i(rst), .req_i(req), .we_i(we), .addr_i(maddr), .wdata_i(mwdata),
    .err_addr_i(err_addr), .ack_o(ack), .err_o(merr), .rdata_o(mrdata));

  always #12.5 clk = ~clk;
  // the mac stalls every other cycle
  always @(negedge clk) rdy <= ~rdy;
  always @(posedge clk)
  begin
    if (bval && rdy)
    begin
      if (nb == 0)
        b0 <= byte_w;
      nb <= nb + 1;
    end
    if (fend)
    begin
      fb <= nb;
      nb <= 0;
      nf <= nf + 1;
      crc_r <= crc;
      bad_r <= bad;
      phy_r <= phy;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse(input int k);
    {late, retry, coll, done, qwr, halt, start} = 7'(1 << k);
    tick(1);
    {late, retry, coll, done, qwr, halt, start} = 7'h00;
  endtask
  task automatic wait_for(input int target, input bit frames);
    int i;
    for (i = 0; i < 3000 && (frames ? nf : far.n_wr) < target; i++)
      tick(1);
    chk(i < 3000, 1);
  endtask
  task automatic serve(input int k);
    wait_for(nf + 1, 1);
    tick(1);
    pulse(k);
  endtask
  task automatic desc(input int i, input logic [31:0] w0, input logic [31:0] w1);
    far.mem[64 + 2 * i] = w0;
    far.mem[65 + 2 * i] = w1;
  endtask
  // software rebuilds the ring from its base before every test case
  task automatic rebase();
    pulse(P_QWR);
    tick(2);
    chk(qptr, 32'h0000_0100);
    chk(go, 1'b0);
  endtask

  task automatic t_basic();
    int w;
    rebase();
    desc(0, 32'h0000_0200, 32'h0000_8001);
    desc(1, 32'h0000_0200, 32'h8000_0000);
    far.mem[128] = 32'haabb_cc5a;
    w = far.n_wr;
    pulse(P_GO);
    pulse(P_GO);
    serve(P_DONE);
    wait_for(w + 1, 0);
    tick(30);
    chk(fb, 60);
    chk({crc_r, b0}, 9'h15a);
    chk(far.wb_a, 32'h0000_0104);
    chk(far.wb_d, 32'h8000_8001);
    chk(qptr, 32'h0000_0108);
    pulse(P_GO);
    tick(30);
    chk({go, qptr}, 33'h0_0000_0108);
    chk(far.n_wr, w + 1);
    $display("basic frame finished");
  endtask

  task automatic t_nocrc();
    int w;
    rebase();
    desc(0, 32'h0000_0201, 32'h0000_0003);
    desc(1, 32'h0000_0300, 32'h4001_8000);
    far.mem[128] = 32'h4433_2211;
    w = far.n_wr;
    pulse(P_GO);
    serve(P_DONE);
    wait_for(w + 1, 0);
    tick(30);
    chk({crc_r, b0}, 9'h022);
    chk(fb, 3);
    chk(far.wb_d, 32'h8000_0003);
    chk(qptr, 32'h0000_0100);
    $display("no-crc frame finished");
  endtask

  task automatic t_errors();
    int w;
    for (int k = 0; k < 3; k++)
    begin
      rebase();
      desc(0, 32'h0000_0200, 32'h0000_8001);
      err_addr = (k == 2) ? 32'h0000_0200 : 32'hffff_ffff;
      w = far.n_wr;
      pulse(P_GO);
      if (k < 2)
        serve(k ? P_LATE : P_RETRY);
      wait_for(w + 1, 0);
      tick(10);
      chk(far.wb_d, exp_st[k]);
      chk({go, qptr}, 33'h0_0000_0100);
    end
    err_addr = 32'hffff_ffff;
    chk({bad_r, phy_r}, 2'h3);
    rebase();
    desc(0, 32'h0000_0200, 32'h0000_0001);
    desc(1, 32'h0000_0200, 32'h8000_8001);
    w = far.n_wr;
    pulse(P_GO);
    wait_for(w + 1, 0);
    tick(10);
    chk(far.wb_d, 32'h9800_0001);
    chk({bad_r, phy_r}, 2'h3);
    chk({go, qptr}, 33'h0_0000_0100);
    $display("error frames finished");
  endtask

  task automatic t_coll_halt();
    int w;
    int n0;
    rebase();
    desc(0, 32'h0000_0200, 32'h0000_0001);
    desc(1, 32'h0000_0200, 32'h0000_8001);
    desc(2, 32'h0000_0200, 32'h0000_8001);
    desc(3, 32'h0000_0200, 32'h8000_0000);
    w = far.n_wr;
    n0 = nf;
    pulse(P_GO);
    serve(P_COLL);
    serve(P_DONE);
    wait_for(w + 1, 0);
    chk(nf, n0 + 2);
    chk(far.wb_a, 32'h0000_0104);
    chk(far.wb_d, 32'h8000_0001);
    tick(3);
    pulse(P_HALT);
    serve(P_DONE);
    wait_for(w + 2, 0);
    tick(40);
    chk(far.n_wr, w + 2);
    chk({go, qptr}, 33'h0_0000_0118);
    en = 1'b0;
    tick(3);
    chk(qptr, 32'h0000_0100);
    en = 1'b1;
    $display("collision and halt finished");
  endtask

  task automatic t_pause_roll();
    int w;
    int r;
    rebase();
    for (int i = 0; i < 4; i++)
      desc(i, 32'h0000_0300, 32'h0001_8000);
    pen = 1'b1;
    pact = 1'b1;
    r = far.n_rd;
    pulse(P_GO);
    tick(20);
    chk(far.n_rd, r);
    pact = 1'b0;
    w = far.n_wr;
    for (int i = 0; i < 4; i++)
      serve(P_DONE);
    wait_for(w + 4, 0);
    tick(30);
    chk(fb, 0);
    chk({go, qptr}, 33'h0_0000_0100);
    pen = 1'b0;
    $display("pause and rollover finished");
  endtask

  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    tick(10);
    rst = 1'b0;
    tick(2);
    t_basic();
    t_nocrc();
    t_errors();
    t_coll_halt();
    t_pause_roll();
    test_done();
  end
  // 13 frames of under 1000 cycles each
  initial
  begin
    repeat (40000) @(posedge clk);
    n_fail++;
    test_done();
  end
endmodule
`default_nettype wire
